// [common/vic_pkg.sv]
// ==========================================================
// Shared constants and types of the vectored interrupt control
package vic_pkg;

   // ==========================================================
   // Register map, byte addresses on the register bus
   localparam logic [7:0]  ADDR_ITC      = 8'h34;
   localparam logic [7:0]  ADDR_VLOW     = 8'h38;
   localparam logic [7:0]  ADDR_VBASE    = 8'h3c;
   localparam logic [7:0]  ADDR_STATUS   = 8'h40;

   // Field positions
   localparam int          ITC_TRAP_BIT  = 7;
   localparam int          ITC_UFO_BIT   = 6;
   localparam int          VLOW_LSB      = 5;
   localparam int          STAT_SAVED_ENABLE_FLAG_BIT = 1;
   localparam int          STAT_MODE_LSB = 2;

   // Values after reset
   localparam logic [2:0]  ITE_RST       = 3'h1;
   localparam logic [2:0]  VLOW_RST      = 3'h0;
   localparam logic [7:0]  VBASE_RST     = 8'h00;
   localparam logic [1:0]  MODE_RST      = 2'h0;

   // Fixed restart addresses
   localparam logic [15:0] NMI_TARGET    = 16'h0066;
   localparam logic [15:0] MODE1_TARGET  = 16'h0038;

   // Wait states added to an external vector fetch
   localparam int          AUTO_WAITS    = 2;

   // Sources: 0 nmi, 1..3 ext_request_0..2, 4..10 peripherals
   localparam int          NUM_SRC       = 11;
   localparam int          NUM_PERIPH    = 7;
   localparam int          SRC_VECT0     = 2;

   // Five-bit fixed codes, ext_request_1 first, falling priority
   localparam logic [4:0]  VEC_CODE [0:8] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08,
                                              5'h0a, 5'h0c, 5'h0e, 5'h10};

   typedef enum logic [2:0] {
      VIC_ACK_NONE,
      VIC_ACK_NMI,
      VIC_ACK_MODE0,
      VIC_ACK_MODE1,
      VIC_ACK_MODE2,
      VIC_ACK_VECT
   } vic_kind_t;

   typedef struct packed {
      vic_kind_t   kind;
      logic [15:0] target;
      logic        push_pc;
      logic        indirect;
      logic [7:0]  opcode;
   } vic_ack_t;

endpackage

// [rtl/vic_top.sv]
`timescale 1ns/1ps
module vic_top
   import vic_pkg::*;
#(
   parameter int T_DIV = 2
)(
   // Clock and reset
   input  wire logic                  CLK,
   input  wire logic                  RST,
   // APB slave
   input  wire logic                  PSEL,
   input  wire logic                  PENABLE,
   input  wire logic                  PWRITE,
   input  wire logic [7:0]            PADDR,
   input  wire logic [31:0]           PWDATA,
   output      logic [31:0]           PRDATA,
   output      logic                  PREADY,
   output      logic                  PSLVERR,
   // Request pins, active low
   input  wire logic                  NMI_N,
   input  wire logic                  EXT_REQUEST_0_N,
   input  wire logic                  EXT_REQUEST_1_N,
   input  wire logic                  EXT_REQUEST_2_N,
   // Data bus as seen during acknowledge
   input  wire logic [7:0]            DATA_IN,
   // Peripheral requests, already gated by their own enable bits
   input  wire logic [NUM_PERIPH-1:0] PERIPH_REQ,
   // Core timing and instruction events
   input  wire logic                  SAMPLE,
   input  wire logic                  CYCLE_END,
   input  wire logic                  ENABLE_INT_INSTR,
   input  wire logic                  MASK_ALL_INSTR,
   input  wire logic                  RETURN_FROM_NONMASK,
   input  wire logic                  SET_RESPONSE_MODE,
   input  wire logic [1:0]            MODE_SEL,
   input  wire logic                  OPCODE_UNDEF,
   input  wire logic                  UFO,
   input  wire logic                  ACK_MORE,
   // Acknowledge bus strobes, active low
   output      logic                  OPCODE_FETCH_STROBE_N,
   output      logic                  IO_REQUEST_STROBE_N,
   // Answer to the core
   output      logic                  ACK_VALID,
   output      vic_ack_t              ACK,
   output      logic                  DMA_MASTER_ENABLE_CLR,
   output      logic                  TRAP_REQ,
   output      logic                  GLOBAL_ENABLE
);

   // ==========================================================
   // State and storage
   typedef enum logic [2:0] {S_IDLE, S_ARMED, S_T1, S_T2, S_TW, S_T3, S_DONE, S_CHK}
      vic_state_t;

   vic_state_t  state;
   vic_kind_t   kind;
   logic [3:0]  src;
   logic [3:0]  sync1;
   logic [3:0]  sync2;
   logic [3:0]  sync3;
   logic [3:0]  pin_lvl;
   logic        nmi_latched;
   logic        global_enable_flag;
   logic        saved_enable_flag;
   logic [2:0]  req_enable;
   logic [1:0]  mode;
   logic [2:0]  vlow;
   logic [7:0]  vbase;
   logic        trap_bit;
   logic [7:0]  data_cap;
   logic [7:0]  tdiv_cnt;
   logic [1:0]  wait_cnt;
   logic [NUM_SRC-1:0] req;
   logic [3:0]  pick;
   logic        t_en;
   logic        nmi_fall;
   logic        accept;
   logic        apb_wr;
   logic        trap_evt;
   vic_kind_t   src_kind;

   // ==========================================================
   // Pin synchronisers
   // Three stages; a level counts only once stages two and three agree
   always_ff @(posedge CLK) begin
      if (RST) begin
         sync1   <= 4'hf;
         sync2   <= 4'hf;
         sync3   <= 4'hf;
         pin_lvl <= 4'hf;
      end else begin
         sync1 <= {EXT_REQUEST_2_N, EXT_REQUEST_1_N, EXT_REQUEST_0_N, NMI_N};
         sync2 <= sync1;
         sync3 <= sync2;
         for (int i = 0; i < 4; i++) begin
            if (sync2[i] == sync3[i]) begin
               pin_lvl[i] <= sync3[i];
            end
         end
      end
   end

   // Falling edge of the qualified non-maskable level
   assign nmi_fall = pin_lvl[0] && (sync2[0] == sync3[0]) && !sync3[0];

   // ==========================================================
   // Request vector and priority pick
   always_comb begin
      req    = '0;
      req[0] = nmi_latched;
      req[1] = !pin_lvl[1] && global_enable_flag && req_enable[0];
      req[2] = !pin_lvl[2] && global_enable_flag && req_enable[1];
      req[3] = !pin_lvl[3] && global_enable_flag && req_enable[2];
      req[NUM_SRC-1:4] = PERIPH_REQ & {NUM_PERIPH{global_enable_flag}};
   end

   // Lowest index wins: nmi, then request 0, then the table order
   always_comb begin
      pick = 4'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            pick = 4'(i);
         end
      end
   end

   // Response kind of the chosen source
   always_comb begin
      if (src == 4'h0) begin
         src_kind = VIC_ACK_NMI;
      end else if (src == 4'h1) begin
         case (mode)
            2'h0:    src_kind = VIC_ACK_MODE0;
            2'h1:    src_kind = VIC_ACK_MODE1;
            default: src_kind = VIC_ACK_MODE2;
         endcase
      end else begin
         src_kind = VIC_ACK_VECT;
      end
   end

   assign accept = (state == S_ARMED) && CYCLE_END;
   assign t_en   = (tdiv_cnt == 8'(T_DIV - 1));

   // ==========================================================
   // Latched non-maskable edge
   // A new edge in the clearing cycle wins so no edge is lost
   always_ff @(posedge CLK) begin
      if (RST) begin
         nmi_latched <= 1'b0;
      end else if (nmi_fall) begin
         nmi_latched <= 1'b1;
      end else if (state == S_IDLE && SAMPLE && pick == 4'h0 && req[0]) begin
         nmi_latched <= 1'b0;
      end
   end

   // ==========================================================
   // T-state divider, restarted at each bus acknowledge
   always_ff @(posedge CLK) begin
      if (RST || accept || (state == S_CHK)) begin
         tdiv_cnt <= 8'h00;
      end else if (t_en) begin
         tdiv_cnt <= 8'h00;
      end else begin
         tdiv_cnt <= tdiv_cnt + 8'h01;
      end
   end

   // ==========================================================
   // Acknowledge sequencer
   always_ff @(posedge CLK) begin
      if (RST) begin
         state    <= S_IDLE;
         src      <= 4'h0;
         kind     <= VIC_ACK_NONE;
         wait_cnt <= 2'h0;
         data_cap <= 8'h00;
      end else begin
         case (state)
            S_IDLE: begin
               if (SAMPLE && (|req)) begin
                  state <= S_ARMED;
                  src   <= pick;
               end
            end
            S_ARMED: begin
               if (CYCLE_END) begin
                  kind <= src_kind;
                  if (src_kind == VIC_ACK_MODE0 || src_kind == VIC_ACK_MODE2) begin
                     state <= S_T1;
                  end else begin
                     state <= S_DONE;
                  end
               end
            end
            S_T1: begin
               if (t_en) begin
                  state    <= S_T2;
                  wait_cnt <= 2'h0;
               end
            end
            S_T2: begin
               if (t_en) begin
                  state <= S_TW;
               end
            end
            S_TW: begin
               if (t_en) begin
                  if (wait_cnt == 2'(AUTO_WAITS - 1)) begin
                     state    <= S_T3;
                     data_cap <= DATA_IN;
                  end else begin
                     wait_cnt <= wait_cnt + 2'h1;
                  end
               end
            end
            S_T3: begin
               if (t_en) begin
                  state <= S_DONE;
               end
            end
            S_DONE: begin
               state <= (kind == VIC_ACK_MODE0) ? S_CHK : S_IDLE;
            end
            S_CHK: begin
               // Further bytes of a multibyte answer start a new read cycle at S_T1
               state <= (ACK_MORE && !OPCODE_UNDEF) ? S_T1 : S_IDLE;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Bus strobes: both low for the whole external vector read
   always_ff @(posedge CLK) begin
      if (RST) begin
         OPCODE_FETCH_STROBE_N <= 1'b1;
         IO_REQUEST_STROBE_N   <= 1'b1;
      end else if ((accept && (src_kind == VIC_ACK_MODE0 || src_kind == VIC_ACK_MODE2))
                   || (state == S_CHK && ACK_MORE && !OPCODE_UNDEF)) begin
         OPCODE_FETCH_STROBE_N <= 1'b0;
         IO_REQUEST_STROBE_N   <= 1'b0;
      end else if (state == S_T3 && t_en) begin
         OPCODE_FETCH_STROBE_N <= 1'b1;
         IO_REQUEST_STROBE_N   <= 1'b1;
      end
   end

   // ==========================================================
   // Answer to the core, standing until the next acknowledge
   always_ff @(posedge CLK) begin
      if (RST) begin
         ACK_VALID <= 1'b0;
         ACK       <= '0;
      end else begin
         ACK_VALID <= (state == S_DONE);
         if (state == S_DONE) begin
            ACK.kind     <= kind;
            ACK.opcode   <= data_cap;
            ACK.push_pc  <= (kind != VIC_ACK_MODE0);
            ACK.indirect <= (kind == VIC_ACK_MODE2) || (kind == VIC_ACK_VECT);
            case (kind)
               VIC_ACK_NMI:   ACK.target <= NMI_TARGET;
               VIC_ACK_MODE1: ACK.target <= MODE1_TARGET;
               VIC_ACK_MODE2: ACK.target <= {vbase, data_cap};
               VIC_ACK_VECT:  ACK.target <= {vbase, vlow,
                                             VEC_CODE[src - 4'(SRC_VECT0)]};
               default:       ACK.target <= 16'h0000;
            endcase
         end
      end
   end

   // ==========================================================
   // Global and saved enable flags
   // Acceptance beats an instruction event landing in the same cycle
   always_ff @(posedge CLK) begin
      if (RST) begin
         global_enable_flag <= 1'b0;
         saved_enable_flag  <= 1'b0;
      end else if (accept && src_kind == VIC_ACK_NMI) begin
         saved_enable_flag  <= global_enable_flag;
         global_enable_flag <= 1'b0;
      end else if (accept) begin
         saved_enable_flag  <= 1'b0;
         global_enable_flag <= 1'b0;
      end else if (RETURN_FROM_NONMASK) begin
         global_enable_flag <= saved_enable_flag;
      end else if (ENABLE_INT_INSTR) begin
         global_enable_flag <= 1'b1;
         saved_enable_flag  <= 1'b1;
      end else if (MASK_ALL_INSTR) begin
         global_enable_flag <= 1'b0;
         saved_enable_flag  <= 1'b0;
      end
   end

   assign GLOBAL_ENABLE = global_enable_flag;

   // Response mode; an unused selector value leaves it alone
   always_ff @(posedge CLK) begin
      if (RST) begin
         mode <= MODE_RST;
      end else if (SET_RESPONSE_MODE && MODE_SEL != 2'h3) begin
         mode <= MODE_SEL;
      end
   end

   // DMA stop and trap request pulses
   assign trap_evt = (state == S_CHK) && OPCODE_UNDEF;
   always_ff @(posedge CLK) begin
      if (RST) begin
         DMA_MASTER_ENABLE_CLR <= 1'b0;
         TRAP_REQ              <= 1'b0;
      end else begin
         DMA_MASTER_ENABLE_CLR <= accept && (src_kind == VIC_ACK_NMI);
         TRAP_REQ              <= trap_evt;
      end
   end

   // ==========================================================
   // APB slave: zero-wait, answer registered in the setup cycle
   assign apb_wr = PSEL && PENABLE && PREADY && PWRITE;

   always_ff @(posedge CLK) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0000_0000;
      end else begin
         PREADY  <= PSEL && !PENABLE;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         if (PSEL && !PENABLE) begin
            case (PADDR)
               ADDR_ITC:    PRDATA <= {24'h0, trap_bit, UFO, 3'h0, req_enable};
               ADDR_VLOW:   PRDATA <= {24'h0, vlow, 5'h00};
               ADDR_VBASE:  PRDATA <= {24'h0, vbase};
               ADDR_STATUS: PRDATA <= {28'h0, mode, saved_enable_flag, global_enable_flag};
               default:     PSLVERR <= 1'b1;
            endcase
         end
      end
   end

   // Writable registers
   always_ff @(posedge CLK) begin
      if (RST) begin
         req_enable <= ITE_RST;
         vlow       <= VLOW_RST;
         vbase      <= VBASE_RST;
      end else if (apb_wr) begin
         if (PADDR == ADDR_ITC) begin
            req_enable <= PWDATA[2:0];
         end
         if (PADDR == ADDR_VLOW) begin
            vlow <= PWDATA[7:VLOW_LSB];
         end
         if (PADDR == ADDR_VBASE) begin
            vbase <= PWDATA[7:0];
         end
      end
   end

   // Trap bit: software may only clear it, and a new trap wins
   always_ff @(posedge CLK) begin
      if (RST) begin
         trap_bit <= 1'b0;
      end else if (trap_evt) begin
         trap_bit <= 1'b1;
      end else if (apb_wr && PADDR == ADDR_ITC && !PWDATA[ITC_TRAP_BIT]) begin
         trap_bit <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence seq_nmi_accept;
      accept && (src_kind == VIC_ACK_NMI);
   endsequence

   sequence seq_mode0_answer;
      ACK_VALID && (ACK.kind == VIC_ACK_MODE0) && (state == S_CHK);
   endsequence

   // Strobe low-time counter
   logic [7:0] strobe_cnt;
   always_ff @(posedge CLK) begin
      if (RST || OPCODE_FETCH_STROBE_N) begin
         strobe_cnt <= 8'h00;
      end else begin
         strobe_cnt <= strobe_cnt + 8'h01;
      end
   end

   AST_NMI_ANSWER: assert property (seq_nmi_accept |=> DMA_MASTER_ENABLE_CLR ##1
      (ACK_VALID && ACK.target == 16'h0066 && ACK.push_pc))
      else $error("nmi answer wrong");
   AST_NMI_FLAGS: assert property (seq_nmi_accept |=>
      (!global_enable_flag && saved_enable_flag == $past(global_enable_flag)))
      else $error("nmi flag save wrong");
   AST_RETURN_FROM_NONMASK: assert property ((RETURN_FROM_NONMASK && !accept) |=>
      global_enable_flag == $past(saved_enable_flag))
      else $error("return did not restore flag");
   AST_NMI_HELD: assert property ((nmi_latched && state != S_IDLE) |=> nmi_latched)
      else $error("nmi latch lost");
   AST_REQ0_TAKEN: assert property ((state == S_IDLE && SAMPLE && !nmi_latched &&
      !pin_lvl[1] && global_enable_flag && req_enable[0]) |=> (state == S_ARMED && src == 4'h1))
      else $error("request 0 not taken");
   AST_REQ0_MASK: assert property ((state == S_IDLE && SAMPLE && !global_enable_flag &&
      !nmi_latched) |=> state == S_IDLE)
      else $error("masked request taken");
   AST_MODE0: assert property (seq_mode0_answer |-> !ACK.push_pc && !ACK.indirect)
      else $error("mode 0 pushed");
   AST_TRAP: assert property ((seq_mode0_answer ##0 OPCODE_UNDEF) |=>
      (TRAP_REQ && trap_bit))
      else $error("trap not raised");
   AST_MODE1: assert property ((ACK_VALID && ACK.kind == VIC_ACK_MODE1) |->
      (ACK.target == 16'h0038 && ACK.push_pc))
      else $error("mode 1 target wrong");
   AST_WAITS: assert property (($rose(OPCODE_FETCH_STROBE_N)) |->
      ($past(strobe_cnt) == 8'(5 * T_DIV - 1) && IO_REQUEST_STROBE_N))
      else $error("vector read length wrong");
   AST_VECT: assert property ((ACK_VALID && ACK.kind == VIC_ACK_VECT) |->
      (ACK.target[15:8] == vbase && ACK.target[7:5] == vlow && !ACK.target[0]))
      else $error("vector pointer wrong");
   AST_EI: assert property ((ENABLE_INT_INSTR && !accept && !RETURN_FROM_NONMASK) |=>
      (global_enable_flag && saved_enable_flag))
      else $error("enable instruction failed");
   AST_RESET: assert property (disable iff (1'b0) $fell(RST) |-> (!global_enable_flag &&
      req_enable == 3'h1 && mode == 2'h0 && vbase == 8'h00 && vlow == 3'h0))
      else $error("reset values wrong");

endmodule

// [tb/vic_partner.sv]
`timescale 1ns/1ps
// ==========================================================
// Vector-supplying peripheral on the acknowledge bus
module vic_partner (
   // Clock
   input  wire logic       clk,
   // Acknowledge strobes and byte on offer
   input  wire logic       fetch_n,
   input  wire logic       io_n,
   input  wire logic [7:0] vec,
   // Data bus toward the block
   output      logic [7:0] data
);
   logic [7:0] idle_pat = 8'h5a;
   // Released bus shows a moving pattern so a stale byte never passes
   always @(posedge clk) idle_pat <= ~idle_pat ^ 8'h01;
   // Byte driven only while both strobes mark a vector read
   assign data = (!fetch_n && !io_n) ? vec : idle_pat;
endmodule

// [tb/vectored_interrupt_control_test.sv]
`timescale 1ns/1ps
// ==========================================================
// Directed bench of the vectored interrupt control
module vectored_interrupt_control_test
   import vic_pkg::*;
;
   localparam int TD = 2;
   logic        clk = '0, rst = '1, psel = '0, pen = '0, pwr = '0, pready, pslverr, err;
   logic [7:0]  paddr = '0, din, vec = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic        nmi_n = '1, r0_n = '1, sample = '0, cend = '0, ei = '0, di = '0;
   logic        return_from_nonmask = '0, setm = '0, undef = '0, ufo = '0, more = '0;
   logic        fs_n, io_n, av, dclr, trap, gen, got, tp;
   logic [1:0]  msel = '0;
   logic [8:0]  src = '0;
   vic_ack_t    ack;
   int          n_fail = 0, comparisons = 0, nd, low;

   vic_top #(.T_DIV(TD)) dut (
      .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .NMI_N(nmi_n),
      .EXT_REQUEST_0_N(r0_n), .EXT_REQUEST_1_N(!src[0]), .EXT_REQUEST_2_N(!src[1]),
      .DATA_IN(din), .PERIPH_REQ(src[8:2]), .SAMPLE(sample), .CYCLE_END(cend),
      .ENABLE_INT_INSTR(ei), .MASK_ALL_INSTR(di), .RETURN_FROM_NONMASK(return_from_nonmask),
      .SET_RESPONSE_MODE(setm), .MODE_SEL(msel), .OPCODE_UNDEF(undef), .UFO(ufo),
      .ACK_MORE(more), .OPCODE_FETCH_STROBE_N(fs_n), .IO_REQUEST_STROBE_N(io_n),
      .ACK_VALID(av), .ACK(ack), .DMA_MASTER_ENABLE_CLR(dclr), .TRAP_REQ(trap),
      .GLOBAL_ENABLE(gen));
   vic_partner peer (.clk(clk), .fetch_n(fs_n), .io_n(io_n), .vec(vec), .data(din));

   // 100 MHz clock
   initial forever #5 clk = ~clk;

   // ==========================================================
   // Shared tasks
   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; read data taken at the rising edge that samples pready high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk) {psel, pen, pwr, paddr, pwdata} <= {2'h2, w, a, d};
      @(posedge clk) pen <= 1'h1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (pready === 1'h1) break;
      end
      if (k == 20) begin
         n_fail++;
         print_verdict();
      end
      {rd, err} = {prdata, pslverr};
      {psel, pen} <= 2'h0;
   endtask

   // Instruction pulse: bit 0 enable, 1 mask-all, 2 return, 3 set mode
   task automatic instr(input logic [3:0] w);
      @(posedge clk) {setm, return_from_nonmask, di, ei} <= w;
      @(posedge clk) {setm, return_from_nonmask, di, ei} <= 4'h0;
      @(posedge clk);
   endtask

   // Let pins settle, pulse sampling point and cycle end, collect the answer
   task automatic take;
      repeat (4) @(posedge clk);
      @(posedge clk) sample <= 1'h1;
      @(posedge clk) {sample, cend} <= 2'h1;
      @(posedge clk) cend <= 1'h0;
      {got, low, nd} = '0;
      for (int k = 0; k < 60 && !got; k++) begin
         @(negedge clk);
         low += (fs_n === 1'h0 && io_n === 1'h0);
         nd += (dclr === 1'h1);
         got = (av === 1'h1);
      end
      // Trap pulse follows the answer by one cycle
      @(negedge clk) tp = (trap === 1'h1);
      repeat (2) @(posedge clk);
   endtask

   task automatic want(input vic_kind_t k, input logic [15:0] t, input logic p, input logic i);
      chk(got, 1'h1);
      chk({ack.kind, ack.target, ack.push_pc, ack.indirect}, {k, t, p, i});
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_reset;
      logic [7:0]  a [5] = '{8'h34, 8'h38, 8'h3c, 8'h40, 8'h44};
      logic [31:0] e [5] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 5; i++) begin
         apb(1'h0, a[i], 32'h0);
         chk(rd, e[i]);
         chk(err, i == 4);
      end
      $display("reset test done");
   endtask

   task automatic t_mode1;
      r0_n <= 1'h0;
      take();
      chk(got, 1'h0);
      instr(4'h1);
      instr(4'h2);
      chk(gen, 1'h0);
      msel <= 2'h1;
      instr(4'h9);
      chk(gen, 1'h1);
      take();
      want(VIC_ACK_MODE1, 16'h0038, 1'h1, 1'h0);
      chk(gen, 1'h0);
      apb(1'h0, 8'h40, 32'h0);
      chk(rd, 32'h4);
      $display("mode 1 test done");
   endtask

   task automatic t_nmi;
      instr(4'h1);
      // Held low three cycles: the pin filter drops anything shorter than two
      @(posedge clk) nmi_n <= 1'h0;
      repeat (3) @(posedge clk);
      nmi_n <= 1'h1;
      take();
      want(VIC_ACK_NMI, 16'h0066, 1'h1, 1'h0);
      chk(nd, 1);
      apb(1'h0, 8'h40, 32'h0);
      chk(rd, 32'h6);
      instr(4'h4);
      chk(gen, 1'h1);
      take();
      want(VIC_ACK_MODE1, 16'h0038, 1'h1, 1'h0);
      r0_n <= 1'h1;
      $display("nmi test done");
   endtask

   task automatic t_mode2;
      apb(1'h1, 8'h3c, 32'h12);
      apb(1'h1, 8'h34, 32'h3);
      msel <= 2'h2;
      vec <= 8'h40;
      instr(4'h9);
      {r0_n, src} <= {1'h0, 9'h1};
      take();
      want(VIC_ACK_MODE2, 16'h1240, 1'h1, 1'h1);
      chk(low, 5 * TD);
      {r0_n, src} <= {1'h1, 9'h0};
      $display("mode 2 test done");
   endtask

   task automatic t_vect;
      apb(1'h1, 8'h34, 32'h1);
      apb(1'h1, 8'h38, 32'ha0);
      instr(4'h1);
      src <= 9'h1;
      take();
      chk(got, 1'h0);
      apb(1'h1, 8'h34, 32'h7);
      for (int i = 0; i < 9; i++) begin
         src <= 9'h3 << i;
         instr(4'h1);
         take();
         want(VIC_ACK_VECT, {8'h12, 3'h5, 5'(2 * i)}, 1'h1, 1'h1);
      end
      src <= 9'h0;
      $display("vectored test done");
   endtask

   task automatic t_mode0;
      msel <= 2'h0;
      vec <= 8'hcb;
      more <= 1'h1;
      instr(4'h9);
      r0_n <= 1'h0;
      take();
      chk({ack.kind, ack.push_pc, ack.opcode}, {VIC_ACK_MODE0, 9'h0cb});
      chk(low, 5 * TD);
      chk(tp, 1'h0);
      // Second byte of a multibyte answer, this one undefined
      {more, undef, ufo, vec} <= {3'h3, 8'hff};
      take();
      chk({ack.kind, ack.push_pc, ack.opcode}, {VIC_ACK_MODE0, 9'h0ff});
      chk(tp, 1'h1);
      apb(1'h0, 8'h34, 32'h0);
      chk(rd, 32'hc7);
      apb(1'h1, 8'h34, 32'h7);
      apb(1'h0, 8'h34, 32'h0);
      chk(rd, 32'h47);
      {r0_n, undef, ufo} <= 3'h4;
      $display("mode 0 test done");
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      t_reset();
      t_mode1();
      t_nmi();
      t_mode2();
      t_vect();
      t_mode0();
      print_verdict();
   end
endmodule
